//--- rtl/cjt_regs.sv
`timescale 1ns/1ps
// Operation
// - threshold between region 3 and 2, resets to 0x372A
// - threshold between region 4 and 3, resets to 0x1F27
// - threshold between region 5 and 4, resets to 0x1BCC
// - threshold between region 6 and 5, resets to 0x18B9
// - threshold between region 6 and 7 (charging off), resets to 0x136D
// - voltage codes region 6 at 9:5, region 5 at 4:0
// - voltage codes region 4 at 14:10, region 3 at 9:5, region 2 at 4:0
// - current codes regions 6 and 5, each resets to 0x0F
// - current codes regions 4, 3, 2 reset 0x1F, 0x1F, 0x0F
// - options register bits 2:0; bit 2 enables C/x termination
// - bit 1 enables lead-acid voltage temperature compensation
// - bit 0 selects per-region codes instead of plain targets
// - absorb phase adds 6-bit absorb increment for phosphate and lead-acid
// - absorb phase ends at programmed absorb time limit
// - equalize phase adds 6-bit equalize increment for lead-acid, default 0x2A
// - equalize seconds counted read-only; duration defaults 0x0E10
// - lithium total charging seconds read-only
// - lithium constant-voltage seconds read-only
// - absorb seconds read-only for phosphate and lead-acid
// - constant-voltage timer reaching its limit ends lithium charging
// - region current codes share the plain current target encoding
module cjt_regs #(
  parameter int CYCLES_PER_SEC = cjt_pkg::CYCLES_PER_SEC
) (
  input  wire logic                  clk,
  input  wire logic                  reset_n,
  input  wire cjt_pkg::cjt_reg_req_s req,
  output logic [15:0]                rdata,
  output logic                       rvalid,
  output logic                       addr_hit,
  input  wire logic [15:0]           ntc_ratio,
  input  wire cjt_pkg::cjt_phase_e   phase,
  input  wire cjt_pkg::cjt_chem_e    chemistry,
  input  wire logic [4:0]            plain_volt_code,
  input  wire logic [4:0]            plain_curr_code,
  input  wire logic [15:0]           const_volt_time_limit,
  output cjt_pkg::cjt_targets_s      targets,
  output logic [15:0]                phosphate_recharge_level
);

  // ----------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------
  logic [15:0] temp_region_3_2_threshold;
  logic [15:0] temp_region_4_3_threshold;
  logic [15:0] temp_region_5_4_threshold;
  logic [15:0] temp_region_6_5_threshold;
  logic [15:0] temp_region_7_6_threshold;
  logic [15:0] region_volt_codes_hot;
  logic [15:0] region_volt_codes_mid;
  logic [15:0] region_curr_codes_hot;
  logic [15:0] region_curr_codes_mid;
  logic [15:0] charger_options;
  logic [15:0] absorb_voltage_increment;
  logic [15:0] absorb_time_limit;
  logic [15:0] equalize_voltage_increment;
  logic [15:0] equalize_duration;
  logic [15:0] phosphate_level;
  logic [15:0] total_charge_seconds;
  logic [15:0] const_volt_seconds;
  logic [15:0] absorb_seconds;
  logic [15:0] equalize_seconds;

  // ----------------------------------------------------------------
  // write path
  // ----------------------------------------------------------------
  function automatic logic [15:0] wr_val(input logic [15:0] cur, input logic [15:0] d,
                                         input logic [15:0] mask, input logic hit);
    wr_val = hit ? (d & mask) : cur;
  endfunction

  wire wr = req.wr;
  wire [7:0] a = req.addr;

  // reserved bits are masked off at write time so they always read zero
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      temp_region_3_2_threshold  <= cjt_pkg::RST_REGION_3_2_THR;
      temp_region_4_3_threshold  <= cjt_pkg::RST_REGION_4_3_THR;
      temp_region_5_4_threshold  <= cjt_pkg::RST_REGION_5_4_THR;
      temp_region_6_5_threshold  <= cjt_pkg::RST_REGION_6_5_THR;
      temp_region_7_6_threshold  <= cjt_pkg::RST_REGION_7_6_THR;
      region_volt_codes_hot      <= cjt_pkg::RST_VOLT_CODES_HOT;
      region_volt_codes_mid      <= cjt_pkg::RST_VOLT_CODES_MID;
      region_curr_codes_hot      <= cjt_pkg::RST_CURR_CODES_HOT;
      region_curr_codes_mid      <= cjt_pkg::RST_CURR_CODES_MID;
      charger_options            <= cjt_pkg::RST_CHARGER_OPTIONS;
      absorb_voltage_increment   <= cjt_pkg::RST_ABSORB_INC;
      absorb_time_limit          <= cjt_pkg::RST_ABSORB_LIMIT;
      equalize_voltage_increment <= cjt_pkg::RST_EQUALIZE_INC;
      equalize_duration          <= cjt_pkg::RST_EQUALIZE_DUR;
      phosphate_level            <= cjt_pkg::RST_PHOSPHATE_RCHG;
    end else begin
      temp_region_3_2_threshold  <= wr_val(temp_region_3_2_threshold, req.wdata, cjt_pkg::MASK_FULL,
                                           wr && a == cjt_pkg::ADDR_REGION_3_2_THR);
      temp_region_4_3_threshold  <= wr_val(temp_region_4_3_threshold, req.wdata, cjt_pkg::MASK_FULL,
                                           wr && a == cjt_pkg::ADDR_REGION_4_3_THR);
      temp_region_5_4_threshold  <= wr_val(temp_region_5_4_threshold, req.wdata, cjt_pkg::MASK_FULL,
                                           wr && a == cjt_pkg::ADDR_REGION_5_4_THR);
      temp_region_6_5_threshold  <= wr_val(temp_region_6_5_threshold, req.wdata, cjt_pkg::MASK_FULL,
                                           wr && a == cjt_pkg::ADDR_REGION_6_5_THR);
      temp_region_7_6_threshold  <= wr_val(temp_region_7_6_threshold, req.wdata, cjt_pkg::MASK_FULL,
                                           wr && a == cjt_pkg::ADDR_REGION_7_6_THR);
      region_volt_codes_hot      <= wr_val(region_volt_codes_hot, req.wdata, cjt_pkg::MASK_TWO_CODES,
                                           wr && a == cjt_pkg::ADDR_VOLT_CODES_HOT);
      region_volt_codes_mid      <= wr_val(region_volt_codes_mid, req.wdata, cjt_pkg::MASK_THREE_CODES,
                                           wr && a == cjt_pkg::ADDR_VOLT_CODES_MID);
      region_curr_codes_hot      <= wr_val(region_curr_codes_hot, req.wdata, cjt_pkg::MASK_TWO_CODES,
                                           wr && a == cjt_pkg::ADDR_CURR_CODES_HOT);
      region_curr_codes_mid      <= wr_val(region_curr_codes_mid, req.wdata, cjt_pkg::MASK_THREE_CODES,
                                           wr && a == cjt_pkg::ADDR_CURR_CODES_MID);
      charger_options            <= wr_val(charger_options, req.wdata, cjt_pkg::MASK_OPTIONS,
                                           wr && a == cjt_pkg::ADDR_CHARGER_OPTIONS);
      absorb_voltage_increment   <= wr_val(absorb_voltage_increment, req.wdata, cjt_pkg::MASK_INCREMENT,
                                           wr && a == cjt_pkg::ADDR_ABSORB_INC);
      absorb_time_limit          <= wr_val(absorb_time_limit, req.wdata, cjt_pkg::MASK_FULL,
                                           wr && a == cjt_pkg::ADDR_ABSORB_LIMIT);
      equalize_voltage_increment <= wr_val(equalize_voltage_increment, req.wdata, cjt_pkg::MASK_INCREMENT,
                                           wr && a == cjt_pkg::ADDR_EQUALIZE_INC);
      equalize_duration          <= wr_val(equalize_duration, req.wdata, cjt_pkg::MASK_FULL,
                                           wr && a == cjt_pkg::ADDR_EQUALIZE_DUR);
      phosphate_level            <= wr_val(phosphate_level, req.wdata, cjt_pkg::MASK_FULL,
                                           wr && a == cjt_pkg::ADDR_PHOSPHATE_RCHG);
    end
  end

  // ----------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------
  logic [15:0] next_rdata;
  logic        next_hit;

  always_comb begin
    next_hit = 1'b1;
    case (a)
      cjt_pkg::ADDR_REGION_3_2_THR:  next_rdata = temp_region_3_2_threshold;
      cjt_pkg::ADDR_REGION_4_3_THR:  next_rdata = temp_region_4_3_threshold;
      cjt_pkg::ADDR_REGION_5_4_THR:  next_rdata = temp_region_5_4_threshold;
      cjt_pkg::ADDR_REGION_6_5_THR:  next_rdata = temp_region_6_5_threshold;
      cjt_pkg::ADDR_REGION_7_6_THR:  next_rdata = temp_region_7_6_threshold;
      cjt_pkg::ADDR_VOLT_CODES_HOT:  next_rdata = region_volt_codes_hot;
      cjt_pkg::ADDR_VOLT_CODES_MID:  next_rdata = region_volt_codes_mid;
      cjt_pkg::ADDR_CURR_CODES_HOT:  next_rdata = region_curr_codes_hot;
      cjt_pkg::ADDR_CURR_CODES_MID:  next_rdata = region_curr_codes_mid;
      cjt_pkg::ADDR_CHARGER_OPTIONS: next_rdata = charger_options;
      cjt_pkg::ADDR_ABSORB_INC:      next_rdata = absorb_voltage_increment;
      cjt_pkg::ADDR_ABSORB_LIMIT:    next_rdata = absorb_time_limit;
      cjt_pkg::ADDR_EQUALIZE_INC:    next_rdata = equalize_voltage_increment;
      cjt_pkg::ADDR_EQUALIZE_DUR:    next_rdata = equalize_duration;
      cjt_pkg::ADDR_PHOSPHATE_RCHG:  next_rdata = phosphate_level;
      cjt_pkg::ADDR_RESERVED_2F:     next_rdata = 16'h0000;
      cjt_pkg::ADDR_TOTAL_SECONDS:   next_rdata = total_charge_seconds;
      cjt_pkg::ADDR_CV_SECONDS:      next_rdata = const_volt_seconds;
      cjt_pkg::ADDR_ABSORB_SECONDS:  next_rdata = absorb_seconds;
      cjt_pkg::ADDR_EQUALIZE_SECS:   next_rdata = equalize_seconds;
      default: begin
        next_rdata = 16'h0000;
        next_hit   = 1'b0;
      end
    endcase
  end

  // read-only registers ignore writes; their value only comes from the timers
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rdata    <= 16'h0000;
      rvalid   <= 1'b0;
      addr_hit <= 1'b0;
    end else begin
      rvalid   <= req.rd;
      addr_hit <= next_hit && (req.rd || req.wr);
      if (req.rd) begin
        rdata <= next_rdata;
      end
    end
  end

  // ----------------------------------------------------------------
  // temperature region selection
  // ----------------------------------------------------------------
  // thermistor ratio falls as temperature rises; region 1 is handled outside
  wire [2:0] region =
    (ntc_ratio > temp_region_3_2_threshold) ? 3'd2 :
    (ntc_ratio > temp_region_4_3_threshold) ? 3'd3 :
    (ntc_ratio > temp_region_5_4_threshold) ? 3'd4 :
    (ntc_ratio > temp_region_6_5_threshold) ? 3'd5 :
    (ntc_ratio > temp_region_7_6_threshold) ? 3'd6 : 3'd7;

  function automatic logic [4:0] pick_code(input logic [2:0] r, input logic [15:0] hot,
                                           input logic [15:0] mid);
    case (r)
      3'd2:    pick_code = mid[cjt_pkg::FLD_LO  +: cjt_pkg::CODE_W];
      3'd3:    pick_code = mid[cjt_pkg::FLD_MID +: cjt_pkg::CODE_W];
      3'd4:    pick_code = mid[cjt_pkg::FLD_HI  +: cjt_pkg::CODE_W];
      3'd5:    pick_code = hot[cjt_pkg::FLD_LO  +: cjt_pkg::CODE_W];
      3'd6:    pick_code = hot[cjt_pkg::FLD_MID +: cjt_pkg::CODE_W];
      default: pick_code = 5'h00;
    endcase
  endfunction

  wire profile_on  = charger_options[cjt_pkg::OPT_PROFILE_BIT];
  wire [4:0] r_volt = pick_code(region, region_volt_codes_hot, region_volt_codes_mid);
  // same current encoding as the plain target: (code + 1) * 1mV / Rsense
  wire [4:0] r_curr = pick_code(region, region_curr_codes_hot, region_curr_codes_mid);

  wire is_lithium = (chemistry == cjt_pkg::CJT_CHEM_LITHIUM);
  wire is_lead    = (chemistry == cjt_pkg::CJT_CHEM_LEAD_ACID);
  wire in_absorb  = (phase == cjt_pkg::CJT_PH_ABSORB) && !is_lithium;
  wire in_equal   = (phase == cjt_pkg::CJT_PH_EQUALIZE) && is_lead;
  wire in_cv      = (phase == cjt_pkg::CJT_PH_CV) && is_lithium;
  wire charging   = (phase != cjt_pkg::CJT_PH_IDLE) && (phase != cjt_pkg::CJT_PH_TERM) && is_lithium;

  wire [5:0] adder =
    in_equal  ? equalize_voltage_increment[cjt_pkg::INC_W-1:0] :
    in_absorb ? absorb_voltage_increment[cjt_pkg::INC_W-1:0] : 6'h00;

  // ----------------------------------------------------------------
  // phase timers
  // ----------------------------------------------------------------
  cjt_sec_timer #(.CYCLES(CYCLES_PER_SEC)) u_total (
    .clk     (clk),
    .reset_n (reset_n),
    .run     (charging),
    .seconds (total_charge_seconds)
  );
  cjt_sec_timer #(.CYCLES(CYCLES_PER_SEC)) u_cv (
    .clk     (clk),
    .reset_n (reset_n),
    .run     (in_cv),
    .seconds (const_volt_seconds)
  );
  cjt_sec_timer #(.CYCLES(CYCLES_PER_SEC)) u_absorb (
    .clk     (clk),
    .reset_n (reset_n),
    .run     (in_absorb),
    .seconds (absorb_seconds)
  );
  cjt_sec_timer #(.CYCLES(CYCLES_PER_SEC)) u_equal (
    .clk     (clk),
    .reset_n (reset_n),
    .run     (in_equal),
    .seconds (equalize_seconds)
  );

  // ----------------------------------------------------------------
  // targets to the charger state machine
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      targets <= '0;
    end else begin
      targets.region        <= region;
      targets.volt_code     <= profile_on ? r_volt : plain_volt_code;
      targets.curr_code     <= profile_on ? r_curr : plain_curr_code;
      targets.charge_off    <= profile_on && (region == 3'd7);
      targets.volt_adder    <= adder;
      targets.cx_term_en    <= charger_options[cjt_pkg::OPT_CX_TERM_BIT];
      targets.temp_comp_en  <= charger_options[cjt_pkg::OPT_TEMP_COMP_BIT] && is_lead;
      targets.absorb_done   <= in_absorb && (absorb_seconds >= absorb_time_limit);
      targets.equalize_done <= in_equal && (equalize_seconds >= equalize_duration);
      targets.cv_done       <= in_cv && (const_volt_seconds >= const_volt_time_limit);
    end
  end

  assign phosphate_recharge_level = phosphate_level;

endmodule

//--- rtl/cjt_pkg.sv
package cjt_pkg;

  // ----------------------------------------------------------------
  // register map (sub-addresses on the serial port)
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_REGION_3_2_THR  = 8'h20;
  localparam logic [7:0] ADDR_REGION_4_3_THR  = 8'h21;
  localparam logic [7:0] ADDR_REGION_5_4_THR  = 8'h22;
  localparam logic [7:0] ADDR_REGION_6_5_THR  = 8'h23;
  localparam logic [7:0] ADDR_REGION_7_6_THR  = 8'h24;
  localparam logic [7:0] ADDR_VOLT_CODES_HOT  = 8'h25;
  localparam logic [7:0] ADDR_VOLT_CODES_MID  = 8'h26;
  localparam logic [7:0] ADDR_CURR_CODES_HOT  = 8'h27;
  localparam logic [7:0] ADDR_CURR_CODES_MID  = 8'h28;
  localparam logic [7:0] ADDR_CHARGER_OPTIONS = 8'h29;
  localparam logic [7:0] ADDR_ABSORB_INC      = 8'h2a;
  localparam logic [7:0] ADDR_ABSORB_LIMIT    = 8'h2b;
  localparam logic [7:0] ADDR_EQUALIZE_INC    = 8'h2c;
  localparam logic [7:0] ADDR_EQUALIZE_DUR    = 8'h2d;
  localparam logic [7:0] ADDR_PHOSPHATE_RCHG  = 8'h2e;
  localparam logic [7:0] ADDR_RESERVED_2F     = 8'h2f;
  localparam logic [7:0] ADDR_TOTAL_SECONDS   = 8'h30;
  localparam logic [7:0] ADDR_CV_SECONDS      = 8'h31;
  localparam logic [7:0] ADDR_ABSORB_SECONDS  = 8'h32;
  localparam logic [7:0] ADDR_EQUALIZE_SECS   = 8'h33;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [15:0] RST_REGION_3_2_THR  = 16'h372a;
  localparam logic [15:0] RST_REGION_4_3_THR  = 16'h1f27;
  localparam logic [15:0] RST_REGION_5_4_THR  = 16'h1bcc;
  localparam logic [15:0] RST_REGION_6_5_THR  = 16'h18b9;
  localparam logic [15:0] RST_REGION_7_6_THR  = 16'h136d;
  localparam logic [15:0] RST_VOLT_CODES_HOT  = 16'h0000;
  localparam logic [15:0] RST_VOLT_CODES_MID  = 16'h0000;
  localparam logic [15:0] RST_CURR_CODES_HOT  = 16'h01ef;
  localparam logic [15:0] RST_CURR_CODES_MID  = 16'h7fef;
  localparam logic [15:0] RST_CHARGER_OPTIONS = 16'h0000;
  localparam logic [15:0] RST_ABSORB_INC      = 16'h0000;
  localparam logic [15:0] RST_ABSORB_LIMIT    = 16'h0000;
  localparam logic [15:0] RST_EQUALIZE_INC    = 16'h002a;
  localparam logic [15:0] RST_EQUALIZE_DUR    = 16'h0e10;
  localparam logic [15:0] RST_PHOSPHATE_RCHG  = 16'h4410;

  // ----------------------------------------------------------------
  // field layout and write masks
  // ----------------------------------------------------------------
  localparam int          CODE_W            = 5;
  localparam int          FLD_LO            = 0;
  localparam int          FLD_MID           = 5;
  localparam int          FLD_HI            = 10;
  localparam logic [15:0] MASK_TWO_CODES    = 16'h03ff;
  localparam logic [15:0] MASK_THREE_CODES  = 16'h7fff;
  localparam logic [15:0] MASK_OPTIONS      = 16'h0007;
  localparam logic [15:0] MASK_INCREMENT    = 16'h003f;
  localparam logic [15:0] MASK_FULL         = 16'hffff;
  localparam int          OPT_CX_TERM_BIT   = 2;
  localparam int          OPT_TEMP_COMP_BIT = 1;
  localparam int          OPT_PROFILE_BIT   = 0;
  localparam int          INC_W             = 6;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ          = 200_000_000;
  localparam int SECOND_S        = 1;
  localparam int CYCLES_PER_SEC  = CLK_HZ * SECOND_S;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    CJT_PH_IDLE,
    CJT_PH_CC,
    CJT_PH_CV,
    CJT_PH_ABSORB,
    CJT_PH_EQUALIZE,
    CJT_PH_TERM
  } cjt_phase_e;

  typedef enum logic [1:0] {
    CJT_CHEM_LITHIUM,
    CJT_CHEM_PHOSPHATE,
    CJT_CHEM_LEAD_ACID
  } cjt_chem_e;

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [7:0]  addr;
    logic [15:0] wdata;
  } cjt_reg_req_s;

  typedef struct packed {
    logic [2:0]  region;
    logic [4:0]  volt_code;
    logic [4:0]  curr_code;
    logic        charge_off;
    logic [5:0]  volt_adder;
    logic        cx_term_en;
    logic        temp_comp_en;
    logic        absorb_done;
    logic        equalize_done;
    logic        cv_done;
  } cjt_targets_s;

endpackage

//--- rtl/cjt_sec_timer.sv
`timescale 1ns/1ps
module cjt_sec_timer #(
  parameter int CYCLES = 200_000_000
) (
  input  wire logic        clk,
  input  wire logic        reset_n,
  input  wire logic        run,
  output logic [15:0]      seconds
);
  logic        run_d;
  logic [31:0] prescale;
  wire         entry     = run && !run_d;
  wire         sec_tick  = run && (prescale == 32'(CYCLES - 1));

  // clears on entry, ticks once per second while running, holds after
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      run_d    <= 1'b0;
      prescale <= 32'h0;
      seconds  <= 16'h0;
    end else begin
      run_d <= run;
      if (entry) begin
        prescale <= 32'h0;
        seconds  <= 16'h0;
      end else if (sec_tick) begin
        prescale <= 32'h0;
        seconds  <= (seconds == 16'hffff) ? seconds : seconds + 16'h1;
      end else if (run) begin
        prescale <= prescale + 32'h1;
      end
    end
  end
endmodule

//--- verif/cjt_regs_assertions.sv
`timescale 1ns/1ps
module cjt_regs_checker (
  input wire logic                  clk,
  input wire logic                  reset_n,
  input wire cjt_pkg::cjt_reg_req_s req,
  input wire logic [15:0]           rdata,
  input wire logic                  rvalid,
  input wire logic                  addr_hit,
  input wire cjt_pkg::cjt_phase_e   phase,
  input wire cjt_pkg::cjt_chem_e    chemistry,
  input wire cjt_pkg::cjt_targets_s targets
);
  // ----------------------------------------------------------------
  // port protocol and target checks
  // ----------------------------------------------------------------
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  wire acc    = req.rd || req.wr;
  wire in_map = (req.addr >= 8'h20) && (req.addr <= 8'h33);
  chk_rvalid_after_rd: assert property (req.rd |=> rvalid)
    else $error("rvalid missing after read");
  chk_rvalid_no_rd: assert property (!req.rd |=> !rvalid)
    else $error("rvalid without read");
  chk_hit_mapped: assert property (acc && in_map |=> addr_hit)
    else $error("addr_hit missing for bank address");
  chk_hit_unmapped: assert property (!(acc && in_map) |=> !addr_hit)
    else $error("addr_hit outside bank");
  chk_unmapped_zero: assert property (req.rd && !in_map |=> rdata == 16'h0000)
    else $error("unmapped read not zero");
  chk_rdata_hold: assert property (!req.rd |=> $stable(rdata))
    else $error("rdata moved without read");
  chk_lithium_no_adder: assert property (chemistry == cjt_pkg::CJT_CHEM_LITHIUM |=> targets.volt_adder == 6'h00)
    else $error("voltage adder for lithium");
  chk_temp_comp_chem: assert property (chemistry != cjt_pkg::CJT_CHEM_LEAD_ACID |=> !targets.temp_comp_en)
    else $error("temperature compensation off lead-acid");
  chk_cv_done_phase: assert property (phase != cjt_pkg::CJT_PH_CV |=> !targets.cv_done)
    else $error("cv_done outside constant-voltage phase");
  chk_off_region7: assert property (targets.charge_off |-> targets.region == 3'h7)
    else $error("charge_off outside region 7");
  cov_read_hit: cover property (rvalid && addr_hit);
  cov_charge_off: cover property (targets.charge_off);
  cov_adder: cover property (targets.volt_adder != 6'h00);
  cov_absorb_done: cover property (targets.absorb_done);
endmodule
bind cjt_regs cjt_regs_checker u_chk (.clk(clk), .reset_n(reset_n), .req(req), .rdata(rdata), .rvalid(rvalid),
  .addr_hit(addr_hit), .phase(phase), .chemistry(chemistry), .targets(targets));

//--- verif/cjt_host_model.sv
`timescale 1ns/1ps
module cjt_host_model (
  input  wire logic           clk,
  output cjt_pkg::cjt_reg_req_s req,
  input  wire logic [15:0]    rdata
);
  initial req = '0;
  // one access per call; idle address and data are inverted so stale values never look valid
  task automatic access(input logic w, input logic [7:0] a, input logic [15:0] d, output logic [15:0] q);
    @(negedge clk);
    req.wr = w;
    req.rd = !w;
    req.addr = a;
    req.wdata = d;
    @(negedge clk);
    q = rdata;
    req.wr = 1'b0;
    req.rd = 1'b0;
    req.addr = ~a;
    req.wdata = ~d;
  endtask
endmodule

//--- verif/test_cjt_regs.sv
`timescale 1ns/1ps
module test_cjt_regs;
  logic                  clk = 1'b0;
  logic                  reset_n = 1'b0;
  cjt_pkg::cjt_reg_req_s req;
  logic [15:0]           rdata, ntc_ratio, cvl, prl, q;
  logic                  rvalid, addr_hit;
  cjt_pkg::cjt_phase_e   phase;
  cjt_pkg::cjt_chem_e    chem;
  logic [4:0]            pv, pc;
  cjt_pkg::cjt_targets_s tg;
  int                    n_mismatch = 0, samples_checked = 0, cycles = 0;
  localparam logic [15:0] RV [15] = '{16'h372a, 16'h1f27, 16'h1bcc, 16'h18b9, 16'h136d, 16'h0000, 16'h0000,
    16'h01ef, 16'h7fef, 16'h0000, 16'h0000, 16'h0000, 16'h002a, 16'h0e10, 16'h4410};
  localparam logic [7:0]  MA [5] = '{8'h25, 8'h26, 8'h29, 8'h2a, 8'h2c};
  localparam logic [15:0] MM [5] = '{16'h03ff, 16'h7fff, 16'h0007, 16'h003f, 16'h003f};
  localparam logic [15:0] RAT [6] = '{16'hffff, 16'h372a, 16'h1f27, 16'h1bcc, 16'h18b9, 16'h136d};
  always #2.5 clk = ~clk;
  // short second keeps the timer scenarios within a few hundred cycles
  cjt_regs #(.CYCLES_PER_SEC(10)) DUT (.clk(clk), .reset_n(reset_n), .req(req), .rdata(rdata), .rvalid(rvalid),
    .addr_hit(addr_hit), .ntc_ratio(ntc_ratio), .phase(phase), .chemistry(chem), .plain_volt_code(pv),
    .plain_curr_code(pc), .const_volt_time_limit(cvl), .targets(tg), .phosphate_recharge_level(prl));
  cjt_host_model host (.clk(clk), .req(req), .rdata(rdata));
  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    samples_checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    host.access(1'b1, a, d, q);
    chk("wr hit", {15'h0, a >= 8'h20 && a <= 8'h33}, {15'h0, addr_hit});
    chk("wr rvalid", 16'h0, {15'h0, rvalid});
  endtask
  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    host.access(1'b0, a, 16'h0000, q);
    chk($sformatf("reg %h", a), e, q);
    chk("rd hit", {15'h0, a >= 8'h20 && a <= 8'h33}, {15'h0, addr_hit});
    chk("rd rvalid", 16'h1, {15'h0, rvalid});
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic final_report;
    $display("mismatches %0d checks %0d", n_mismatch, samples_checked);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      n_mismatch++;
      final_report();
    end
  end
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  initial begin
    ntc_ratio = 16'hffff;
    phase = cjt_pkg::CJT_PH_IDLE;
    chem = cjt_pkg::CJT_CHEM_LITHIUM;
    pv = 5'h11;
    pc = 5'h07;
    cvl = 16'h0002;
    repeat (16) @(posedge clk);
    @(negedge clk) reset_n = 1'b1;
    for (int i = 0; i < 15; i++) rd(8'h20 + 8'(i), RV[i]);
    for (int i = 0; i < 5; i++) begin
      wr(MA[i], 16'hffff);
      rd(MA[i], MM[i]);
    end
    wr(8'h2e, 16'ha5c3);
    rd(8'h2e, 16'ha5c3);
    chk("recharge level", 16'ha5c3, prl);
    for (int i = 0; i < 5; i++) begin
      wr(8'h2f + 8'(i), 16'hffff);
      rd(8'h2f + 8'(i), 16'h0000);
    end
    wr(8'h40, 16'hffff);
    rd(8'h40, 16'h0000);
    wr(8'h26, {1'b0, 5'd4, 5'd3, 5'd2});
    wr(8'h25, {6'h00, 5'd6, 5'd5});
    wr(8'h28, {1'b0, 5'd12, 5'd11, 5'd10});
    wr(8'h27, {6'h00, 5'd14, 5'd13});
    wr(8'h29, 16'h0001);
    // equal ratio must fall to the warmer region: the comparison is strict
    for (int i = 0; i < 6; i++) begin
      ntc_ratio = RAT[i];
      cyc(2);
      chk("region", 16'(i + 2), {13'h0, tg.region});
      chk("volt code", (i == 5) ? 16'h0 : 16'(i + 2), {11'h0, tg.volt_code});
      chk("curr code", (i == 5) ? 16'h0 : 16'(i + 10), {11'h0, tg.curr_code});
      chk("charge off", (i == 5) ? 16'h1 : 16'h0, {15'h0, tg.charge_off});
    end
    wr(8'h29, 16'h0006);
    chem = cjt_pkg::CJT_CHEM_LEAD_ACID;
    ntc_ratio = 16'hffff;
    cyc(2);
    chk("plain volt", {11'h0, pv}, {11'h0, tg.volt_code});
    chk("plain curr", {11'h0, pc}, {11'h0, tg.curr_code});
    chk("cx term", 16'h1, {15'h0, tg.cx_term_en});
    chk("temp comp", 16'h1, {15'h0, tg.temp_comp_en});
    wr(8'h2c, 16'h0015);
    wr(8'h2a, 16'h000b);
    wr(8'h2b, 16'h0003);
    wr(8'h2d, 16'h0001);
    phase = cjt_pkg::CJT_PH_EQUALIZE;
    cyc(2);
    chk("equalize adder", 16'h0015, {10'h0, tg.volt_adder});
    chk("equalize early", 16'h0, {15'h0, tg.equalize_done});
    cyc(11);
    chk("equalize done", 16'h1, {15'h0, tg.equalize_done});
    rd(8'h33, 16'h0001);
    phase = cjt_pkg::CJT_PH_ABSORB;
    cyc(2);
    chk("absorb adder", 16'h000b, {10'h0, tg.volt_adder});
    cyc(19);
    rd(8'h32, 16'h0002);
    cyc(20);
    chk("absorb done", 16'h1, {15'h0, tg.absorb_done});
    phase = cjt_pkg::CJT_PH_IDLE;
    cyc(3);
    phase = cjt_pkg::CJT_PH_ABSORB;
    cyc(2);
    rd(8'h32, 16'h0000);
    chem = cjt_pkg::CJT_CHEM_PHOSPHATE;
    cyc(2);
    chk("phosphate adder", 16'h000b, {10'h0, tg.volt_adder});
    chk("phosphate comp", 16'h0, {15'h0, tg.temp_comp_en});
    chem = cjt_pkg::CJT_CHEM_LITHIUM;
    phase = cjt_pkg::CJT_PH_CV;
    cyc(34);
    rd(8'h31, 16'h0003);
    rd(8'h30, 16'h0003);
    chk("cv done", 16'h1, {15'h0, tg.cv_done});
    // mid-run reset must bring back defaults and clear the running timer
    reset_n = 1'b0;
    cyc(2);
    reset_n = 1'b1;
    rd(8'h2c, 16'h002a);
    rd(8'h31, 16'h0000);
    final_report();
  end
endmodule
